// *** src/irq_vector_map.sv ***
// Notes on behaviour
// - each vector entry is four bytes
// - accepted request loads handler address into pc
// - fixed region fffdc..fffff, never relocated
// - undefined, overflow, break use fixed entries
// - address match, nmi, reset fixed entries
// - oscillation-stop and watchdog share one entry
// - fixed high bytes double as id storage
// - break byte ffh selects relocatable break
// - relocatable area is 256 bytes at base
// - even base fetches faster than odd
// - entry n at base plus four n
// - break and swi ignore global enable
// - peripheral vectors maskable, need acknowledge
// - slots 6,7 select timer or collision
// - i2c mode: nack transmit, ack receive
// - collision slots signal start/stop in i2c
// - remap puts can/key on 13, converter 14
`timescale 1ns/1ps
`default_nettype none

module irq_vector_map
  import irq_vector_map_pkg::*;
(
  // clock and reset
  input  wire logic                             clk_in,
  input  wire logic                             sys_rst_in,
  // acceptance request from the sequencer
  input  wire logic                             accept_in,
  input  wire irq_vector_map_pkg::vec_src_e     accept_src_in,
  input  wire logic [irq_vector_map_pkg::NUM_W-1:0] accept_num_in,
  input  wire logic                             global_enable_in,
  // relocatable base and break override byte
  input  wire logic [irq_vector_map_pkg::ADDR_W-1:0] vector_table_base_in,
  input  wire logic [7:0]                       break_flag_byte_in,
  // vector memory read port
  output logic [irq_vector_map_pkg::ADDR_W-1:0] fetch_addr_out,
  output logic                                  fetch_req_out,
  input  wire logic [irq_vector_map_pkg::ADDR_W-1:0] fetch_data_in,
  input  wire logic                             fetch_ack_in,
  // program counter load
  output logic [irq_vector_map_pkg::ADDR_W-1:0] pc_load_out,
  output logic                                  pc_load_out_valid_out,
  output logic                                  busy_out,
  output logic                                  refused_out,
  output logic                                  id_check_region_out,
  // raw peripheral sources
  input  wire logic [31:0]                      periph_req_in,
  input  wire logic [31:0]                      periph_mask_in,
  input  wire logic [6:0]                       alt_req_in,
  input  wire logic                             serial8_req_in,
  input  wire logic                             serial9_req_in,
  input  wire logic                             pin8_req_in,
  input  wire logic                             pin9_req_in,
  input  wire logic [2:0]                       i2c_mode_in,
  input  wire logic [5:0]                       i2c_ackev_in,
  input  wire logic [2:0]                       i2c_startstop_in,
  input  wire logic                             can_error_req_in,
  input  wire logic                             key_req_in,
  input  wire logic                             conv_req_in,
  // source select bits
  input  wire logic                             slot5_source_select,
  input  wire logic                             slot6_source_select,
  input  wire logic                             slot7_source_select,
  input  wire logic                             slot8_source_select,
  input  wire logic                             slot8_serial_companion_select,
  input  wire logic                             slot9_source_select,
  input  wire logic                             slot9_serial_companion_select,
  input  wire logic                             slot23_source_select,
  input  wire logic                             slot24_source_select,
  input  wire logic                             slot26_source_select,
  input  wire logic                             slot27_source_select,
  input  wire logic                             slot13_remap_select,
  input  wire logic                             vector_remap_enable,
  // routed peripheral requests toward the priority logic
  output logic [31:0]                           slot_req_out
);
  import irq_vector_map_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // four-byte entries
  function automatic logic [ADDR_W-1:0] reloc_entry(input logic [ADDR_W-1:0] base,
                                                    input logic [NUM_W-1:0]  num);
    logic [ADDR_W-1:0] off;
    off = ADDR_W'(num) * ADDR_W'(ENTRY_BYTES);
    reloc_entry = base + off;
  endfunction : reloc_entry

  function automatic logic in_fixed(input logic [ADDR_W-1:0] a);
    in_fixed = (a >= FIXED_LO_ADDR) && (a <= FIXED_HI_ADDR);
  endfunction : in_fixed

  // ----------------------------------------------------------------
  // slot routing
  // ----------------------------------------------------------------
  // alt_req_in bits: 0 slot5, 1 slot6, 2 slot7, 3 slot23, 4 slot24,
  // 5 slot26, 6 slot27 alternates; absent alternates rely on software
  // clear selects on small package
  logic slot8_serial;
  logic slot9_serial;
  logic [2:0] coll_src;
  logic [2:0] coll_raw;
  logic [5:0] ser_src;

  assign slot8_serial = slot8_source_select & slot8_serial_companion_select;
  assign slot9_serial = slot9_source_select & slot9_serial_companion_select;

  // channel 0 serves slots 10/15/16, 1 slots 7/17/18, 2 slots 6/19/20
  assign coll_raw = {alt_req_in[1], alt_req_in[2], periph_req_in[SLOT_10]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_coll
      assign coll_src[gi] = i2c_mode_in[gi] ? i2c_startstop_in[gi] : coll_raw[gi];
    end
    for (gi = 0; gi < 6; gi++) begin : g_ser
      assign ser_src[gi] = i2c_mode_in[gi/2] ? i2c_ackev_in[gi]
                                             : periph_req_in[SLOT_15+gi];
    end
  endgenerate

  logic [31:0] routed;
  always_comb begin
    routed = periph_req_in;
    routed[SLOT_5] = slot5_source_select ? alt_req_in[0] : periph_req_in[SLOT_5];
    routed[SLOT_6] = slot6_source_select ? coll_src[2] : periph_req_in[SLOT_6];
    routed[SLOT_7] = slot7_source_select ? coll_src[1] : periph_req_in[SLOT_7];
    routed[SLOT_8] = slot8_serial ? serial8_req_in : pin8_req_in;
    routed[SLOT_9] = slot9_serial ? serial9_req_in : pin9_req_in;
    routed[SLOT_10] = coll_src[0];
    routed[SLOT_20:SLOT_15] = ser_src;
    routed[SLOT_23] = slot23_source_select ? alt_req_in[3] : periph_req_in[SLOT_23];
    routed[SLOT_24] = slot24_source_select ? alt_req_in[4] : periph_req_in[SLOT_24];
    routed[SLOT_26] = slot26_source_select ? alt_req_in[5] : periph_req_in[SLOT_26];
    routed[SLOT_27] = slot27_source_select ? alt_req_in[6] : periph_req_in[SLOT_27];
    if (vector_remap_enable) begin
      routed[SLOT_13] = slot13_remap_select ? key_req_in : can_error_req_in;
      routed[SLOT_14] = conv_req_in;
    end
    routed[0] = 1'b0;
  end

  assign slot_req_out = routed & periph_mask_in;

  // ----------------------------------------------------------------
  // vector address selection
  // ----------------------------------------------------------------
  logic              break_reloc;
  logic              maskable_ok;
  logic              take;
  logic [ADDR_W-1:0] vec_addr;

  assign break_reloc = (break_flag_byte_in == BREAK_RELOC_VAL);

  // peripheral needs enable and slot request
  assign maskable_ok = global_enable_in
                       && (accept_num_in != SWI_BREAK_NUM)
                       && (accept_num_in <= SWI_LAST_PERIPH)
                       && slot_req_out[accept_num_in[4:0]];
  assign take = accept_in && ((accept_src_in != SRC_PERIPH) || maskable_ok);

  always_comb begin
    unique case (accept_src_in)
      SRC_UNDEF:  vec_addr = VEC_UNDEF_ADDR;
      SRC_OVFL:   vec_addr = VEC_OVFL_ADDR;
      SRC_BREAK:  vec_addr = break_reloc ? reloc_entry(vector_table_base_in, SWI_BREAK_NUM)
                                         : VEC_BREAK_ADDR;
      SRC_AMATCH: vec_addr = VEC_AMATCH_ADDR;
      SRC_STEP:   vec_addr = VEC_STEP_ADDR;
      SRC_OSCWDT: vec_addr = VEC_OSCWDT_ADDR;
      SRC_DEBUG:  vec_addr = VEC_DEBUG_ADDR;
      SRC_NMI:    vec_addr = VEC_NMI_ADDR;
      SRC_RESET:  vec_addr = VEC_RESET_ADDR;
      SRC_SWI,
      SRC_PERIPH: vec_addr = reloc_entry(vector_table_base_in, accept_num_in);
      default:    vec_addr = VEC_RESET_ADDR;
    endcase
  end

  // ----------------------------------------------------------------
  // fetch sequencer
  // ----------------------------------------------------------------
  seq_state_e        state_r, state_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] pc_r;
  logic [2:0]        wait_r;
  logic              pc_vld_r;
  logic              refused_r;
  logic              fixed_r;
  logic [2:0]        wait_load;

  assign wait_load = vector_table_base_in[0] && (accept_src_in inside {SRC_SWI, SRC_PERIPH}
                     || (accept_src_in == SRC_BREAK && break_reloc))
                     ? FETCH_ODD_CYC : FETCH_EVEN_CYC;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (take) state_nxt = ST_FETCH;
      ST_FETCH: if (wait_r == 3'h0 && fetch_ack_in) state_nxt = ST_LOAD;
      ST_LOAD:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r   <= ST_IDLE;
      addr_r    <= BASE_RST;
      pc_r      <= BASE_RST;
      wait_r    <= 3'h0;
      pc_vld_r  <= 1'b0;
      refused_r <= 1'b0;
      fixed_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      pc_vld_r  <= 1'b0;
      refused_r <= (state_r == ST_IDLE) && accept_in && !take;
      if (state_r == ST_IDLE && take) begin
        addr_r  <= vec_addr;
        wait_r  <= wait_load - 3'h1;
        fixed_r <= in_fixed(vec_addr);
      end else if (state_r == ST_FETCH && wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end
      if (state_r == ST_FETCH && wait_r == 3'h0 && fetch_ack_in) begin
        pc_r     <= fetch_data_in;
        pc_vld_r <= 1'b1;
      end
    end
  end

  assign fetch_addr_out        = addr_r;
  assign fetch_req_out         = (state_r == ST_FETCH) && (wait_r == 3'h0);
  assign pc_load_out           = pc_r;
  assign pc_load_out_valid_out = pc_vld_r;
  assign busy_out              = (state_r != ST_IDLE);
  assign refused_out           = refused_r;
  assign id_check_region_out   = fixed_r;

endmodule : irq_vector_map

`default_nettype wire

// *** src/irq_vector_map_pkg.sv ***
package irq_vector_map_pkg;

  // ----------------------------------------------------------------
  // address widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int NUM_W  = 6;
  localparam int SLOT_N = 32;

  // ----------------------------------------------------------------
  // fixed vector entries
  // ----------------------------------------------------------------
  localparam logic [19:0] FIXED_LO_ADDR   = 20'hfffdc;
  localparam logic [19:0] FIXED_HI_ADDR   = 20'hfffff;
  localparam logic [19:0] VEC_UNDEF_ADDR  = 20'hfffdc;
  localparam logic [19:0] VEC_OVFL_ADDR   = 20'hfffe0;
  localparam logic [19:0] VEC_BREAK_ADDR  = 20'hfffe4;
  localparam logic [19:0] VEC_AMATCH_ADDR = 20'hfffe8;
  localparam logic [19:0] VEC_STEP_ADDR   = 20'hfffec;
  localparam logic [19:0] VEC_OSCWDT_ADDR = 20'hffff0;
  localparam logic [19:0] VEC_DEBUG_ADDR  = 20'hffff4;
  localparam logic [19:0] VEC_NMI_ADDR    = 20'hffff8;
  localparam logic [19:0] VEC_RESET_ADDR  = 20'hffffc;
  localparam logic [19:0] BREAK_FLAG_ADDR = 20'hfffe7;
  localparam logic [7:0]  BREAK_RELOC_VAL = 8'hff;

  // ----------------------------------------------------------------
  // relocatable table
  // ----------------------------------------------------------------
  localparam int          ENTRY_BYTES     = 4;
  localparam int          RELOC_BYTES     = 256;
  localparam logic [5:0]  SWI_BREAK_NUM   = 6'h00;
  localparam logic [5:0]  SWI_LAST_PERIPH = 6'h1f;
  localparam logic [19:0] BASE_RST        = 20'h00000;

  // ----------------------------------------------------------------
  // shared slot numbers
  // ----------------------------------------------------------------
  localparam int SLOT_5    = 5;
  localparam int SLOT_6    = 6;
  localparam int SLOT_7    = 7;
  localparam int SLOT_8    = 8;
  localparam int SLOT_9    = 9;
  localparam int SLOT_10   = 10;
  localparam int SLOT_13   = 13;
  localparam int SLOT_14   = 14;
  localparam int SLOT_15   = 15;
  localparam int SLOT_20   = 20;
  localparam int SLOT_23   = 23;
  localparam int SLOT_24   = 24;
  localparam int SLOT_26   = 26;
  localparam int SLOT_27   = 27;

  // ----------------------------------------------------------------
  // fetch timing (cycles of the sequencer read)
  // ----------------------------------------------------------------
  localparam logic [2:0] FETCH_EVEN_CYC = 3'h2;
  localparam logic [2:0] FETCH_ODD_CYC  = 3'h4;

  // ----------------------------------------------------------------
  // vector sources
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_UNDEF  = 4'h0,
    SRC_OVFL   = 4'h1,
    SRC_BREAK  = 4'h2,
    SRC_AMATCH = 4'h3,
    SRC_STEP   = 4'h4,
    SRC_OSCWDT = 4'h5,
    SRC_DEBUG  = 4'h6,
    SRC_NMI    = 4'h7,
    SRC_RESET  = 4'h8,
    SRC_SWI    = 4'h9,
    SRC_PERIPH = 4'ha
  } vec_src_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_LOAD  = 2'b10
  } seq_state_e;

endpackage : irq_vector_map_pkg

// *** verif/irq_vector_map_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_vector_map_monitor
  import irq_vector_map_pkg::*;
(
  // clock and reset
  input wire logic                         clk_in,
  input wire logic                         sys_rst_in,
  // acceptance
  input wire logic                         accept_in,
  input wire irq_vector_map_pkg::vec_src_e accept_src_in,
  input wire logic [5:0]                   accept_num_in,
  input wire logic                         global_enable_in,
  input wire logic [19:0]                  vector_table_base_in,
  input wire logic [7:0]                   break_flag_byte_in,
  // fetch and load
  input wire logic [19:0]                  fetch_addr_out,
  input wire logic                         fetch_req_out,
  input wire logic [19:0]                  fetch_data_in,
  input wire logic                         fetch_ack_in,
  input wire logic [19:0]                  pc_load_out,
  input wire logic                         pc_load_out_valid_out,
  input wire logic                         busy_out,
  input wire logic                         refused_out,
  input wire logic                         id_check_region_out,
  // routing
  input wire logic [31:0]                  periph_req_in,
  input wire logic [31:0]                  periph_mask_in,
  input wire logic [31:0]                  slot_req_out,
  input wire logic                         slot6_source_select,
  input wire logic [2:0]                   i2c_mode_in,
  input wire logic [5:0]                   i2c_ackev_in,
  input wire logic [2:0]                   i2c_startstop_in,
  input wire logic                         can_error_req_in,
  input wire logic                         key_req_in,
  input wire logic                         conv_req_in,
  input wire logic                         slot13_remap_select,
  input wire logic                         vector_remap_enable
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire take = accept_in && !busy_out;
  wire is_fixed = accept_src_in inside {SRC_UNDEF, SRC_OVFL, SRC_AMATCH, SRC_OSCWDT, SRC_NMI,
                                        SRC_RESET};
  wire brk_fixed = accept_src_in == SRC_BREAK && break_flag_byte_in != BREAK_RELOC_VAL;
  wire periph_ok = global_enable_in && !accept_num_in[5] && accept_num_in != 6'h00
                   && slot_req_out[accept_num_in[4:0]];
  wire reloc_take = take && (accept_src_in == SRC_SWI || accept_src_in == SRC_BREAK && !brk_fixed
                    || accept_src_in == SRC_PERIPH && periph_ok);
  // break relocates to entry zero whatever number rides along
  wire [19:0] reloc_exp = vector_table_base_in
                        + (accept_src_in == SRC_BREAK ? 20'h00000 : {12'h000, accept_num_in, 2'b00});
  function automatic logic [19:0] fixed_of(input vec_src_e s);
    case (s)
      SRC_UNDEF:  return VEC_UNDEF_ADDR;
      SRC_OVFL:   return VEC_OVFL_ADDR;
      SRC_AMATCH: return VEC_AMATCH_ADDR;
      SRC_OSCWDT: return VEC_OSCWDT_ADDR;
      SRC_NMI:    return VEC_NMI_ADDR;
      default:    return VEC_RESET_ADDR;
    endcase
  endfunction : fixed_of
  sequence s_even_wait;
    !fetch_req_out ##1 fetch_req_out;
  endsequence
  sequence s_odd_wait;
    !fetch_req_out [*3] ##1 fetch_req_out;
  endsequence
  sequence s_load;
    pc_load_out_valid_out && pc_load_out == $past(fetch_data_in);
  endsequence
  a_fixed_entry_addr:
    assert property (take && is_fixed |=> (id_check_region_out
      && fetch_addr_out == fixed_of($past(accept_src_in))) ##0 s_even_wait)
      else $error("fixed entry wrong");
  a_break_fixed_entry:
    assert property (take && brk_fixed |=> fetch_addr_out == VEC_BREAK_ADDR)
      else $error("break entry wrong");
  a_reloc_entry_addr:
    assert property (reloc_take |=> fetch_addr_out == $past(reloc_exp))
      else $error("relocatable entry wrong");
  a_even_base_fast:
    assert property (reloc_take && !vector_table_base_in[0] |=> s_even_wait)
      else $error("even base fetch late");
  a_odd_base_slow:
    assert property (reloc_take && vector_table_base_in[0] |=> s_odd_wait)
      else $error("odd base fetch timing wrong");
  a_swi_ignores_enable:
    assert property (take && accept_src_in == SRC_SWI && !global_enable_in
      |=> busy_out && !refused_out) else $error("swi blocked by enable");
  a_periph_refused:
    assert property (take && accept_src_in == SRC_PERIPH && !periph_ok
      |=> refused_out && !busy_out) else $error("masked peripheral taken");
  a_req_holds_addr:
    assert property (fetch_req_out && !fetch_ack_in |=> fetch_req_out && $stable(fetch_addr_out))
      else $error("fetch dropped before ack");
  a_pc_from_vector:
    assert property (fetch_req_out && fetch_ack_in |=> s_load) else $error("pc load wrong");
  a_slot6_timer:
    assert property (!slot6_source_select |-> slot_req_out[6] == (periph_req_in[6]
      && periph_mask_in[6])) else $error("slot 6 routing wrong");
  a_i2c_ack_vectors:
    assert property (i2c_mode_in[0] |-> slot_req_out[16:15] == (i2c_ackev_in[1:0]
      & periph_mask_in[16:15])) else $error("i2c ack vector routing wrong");
  a_i2c_startstop:
    assert property (i2c_mode_in[0] |-> slot_req_out[10] == (i2c_startstop_in[0]
      && periph_mask_in[10])) else $error("slot 10 start/stop routing wrong");
  a_remap_slots:
    assert property (vector_remap_enable |-> slot_req_out[14:13] == ({conv_req_in,
      slot13_remap_select ? key_req_in : can_error_req_in} & periph_mask_in[14:13]))
      else $error("remapped slots wrong");
endmodule : irq_vector_map_monitor
bind irq_vector_map irq_vector_map_monitor irq_vector_map_monitor_inst (.clk_in, .sys_rst_in,
  .accept_in, .accept_src_in, .accept_num_in, .global_enable_in, .vector_table_base_in,
  .break_flag_byte_in, .fetch_addr_out, .fetch_req_out, .fetch_data_in, .fetch_ack_in,
  .pc_load_out, .pc_load_out_valid_out, .busy_out, .refused_out, .id_check_region_out,
  .periph_req_in, .periph_mask_in, .slot_req_out, .slot6_source_select, .i2c_mode_in,
  .i2c_ackev_in, .i2c_startstop_in, .can_error_req_in, .key_req_in, .conv_req_in,
  .slot13_remap_select, .vector_remap_enable);
`default_nettype wire

// *** verif/vector_fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module vector_fetch_model (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  // vector read port
  input wire logic        req_in,
  input wire logic [19:0] addr_in,
  input wire logic [1:0]  delay_in,
  output logic            ack_out,
  output logic [19:0]     data_out
);
  logic [1:0] wait_r;
  initial data_out = 20'h00000;
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    // outside an answer the bus keeps toggling so stale data never matches
    data_out <= ~data_out;
    if (sys_rst_in) begin
      wait_r <= 2'h0;
    end else if (req_in && !ack_out) begin
      if (wait_r == delay_in) begin
        ack_out <= 1'b1;
        data_out <= ~addr_in;
        wait_r <= 2'h0;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule : vector_fetch_model
`default_nettype wire

// *** verif/irq_vector_map_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_vector_map_tb;
  import irq_vector_map_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, accept_in = 1'b0, global_enable_in = 1'b0;
  vec_src_e accept_src_in = SRC_RESET;
  logic [5:0] accept_num_in = 6'h00, n;
  logic [19:0] vector_table_base_in = 20'h00000, fetch_addr_out, fetch_data_in, pc_load_out;
  logic [7:0] break_flag_byte_in = 8'h00;
  logic [31:0] periph_req_in = 32'h0, periph_mask_in = 32'h0, slot_req_out;
  logic [25:0] misc = 26'h0;
  logic [12:0] sel = 13'h0;
  logic [1:0] delay = 2'h0;
  logic fetch_req_out, fetch_ack_in, pc_load_out_valid_out, busy_out, refused_out, id_check_region_out;
  logic [20:0] exp_q[$], want;
  int err_count = 0, n_checks = 0, seed = 28361;
  vec_src_e fx[7] = '{SRC_UNDEF, SRC_OVFL, SRC_BREAK, SRC_AMATCH, SRC_OSCWDT, SRC_NMI, SRC_RESET};
  logic [19:0] fa[7] = '{VEC_UNDEF_ADDR, VEC_OVFL_ADDR, VEC_BREAK_ADDR, VEC_AMATCH_ADDR,
                         VEC_OSCWDT_ADDR, VEC_NMI_ADDR, VEC_RESET_ADDR};
  logic [5:0] nums[4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
  always #20 clk_in = ~clk_in;
  irq_vector_map irq_vector_map_inst (.clk_in, .sys_rst_in, .accept_in, .accept_src_in,
    .accept_num_in, .global_enable_in, .vector_table_base_in, .break_flag_byte_in,
    .fetch_addr_out, .fetch_req_out, .fetch_data_in, .fetch_ack_in, .pc_load_out,
    .pc_load_out_valid_out, .busy_out, .refused_out, .id_check_region_out, .periph_req_in,
    .periph_mask_in, .alt_req_in(misc[6:0]), .serial8_req_in(misc[7]), .serial9_req_in(misc[8]),
    .pin8_req_in(misc[9]), .pin9_req_in(misc[10]), .i2c_mode_in(misc[13:11]),
    .i2c_ackev_in(misc[19:14]), .i2c_startstop_in(misc[22:20]), .can_error_req_in(misc[23]),
    .key_req_in(misc[24]), .conv_req_in(misc[25]), .slot5_source_select(sel[0]),
    .slot6_source_select(sel[1]), .slot7_source_select(sel[2]), .slot8_source_select(sel[3]),
    .slot8_serial_companion_select(sel[4]), .slot9_source_select(sel[5]),
    .slot9_serial_companion_select(sel[6]), .slot23_source_select(sel[7]),
    .slot24_source_select(sel[8]), .slot26_source_select(sel[9]), .slot27_source_select(sel[10]),
    .slot13_remap_select(sel[11]), .vector_remap_enable(sel[12]), .slot_req_out);
  vector_fetch_model vector_fetch_model_inst (.clk_in, .sys_rst_in, .req_in(fetch_req_out),
    .addr_in(fetch_addr_out), .delay_in(delay), .ack_out(fetch_ack_in), .data_out(fetch_data_in));
  task automatic chk(input string what, input logic [20:0] want_v, input logic [20:0] seen);
    n_checks++;
    if (seen !== want_v) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, want_v, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic run(input vec_src_e src, input logic [5:0] num, input logic [19:0] addr,
                     input logic refuse);
    int i;
    for (i = 0; i < 16 && busy_out !== 1'b0; i++) @(posedge clk_in) #1;
    misc = 26'($random(seed));
    sel = 13'($random(seed));
    sel[4] = sel[3];
    sel[6] = sel[5];
    // full package, alternates present; serial companion selects follow slot 8/9 selects
    delay = 2'($random(seed));
    accept_src_in = src;
    accept_num_in = num;
    accept_in = 1'b1;
    // model answers with the complement of the entry address
    exp_q.push_back(refuse ? 21'h100000 : {1'b0, ~addr});
    @(posedge clk_in) #1;
    accept_in = 1'b0;
    @(posedge clk_in) #1;
    for (i = 0; i < 16 && busy_out !== 1'b0; i++) @(posedge clk_in) #1;
  endtask : run
  always @(negedge clk_in) begin
    if (!sys_rst_in && (pc_load_out_valid_out !== 1'b0 || refused_out !== 1'b0)) begin
      want = exp_q.size() > 0 ? exp_q.pop_front() : 21'h1fffff;
      chk("result", want, {refused_out, refused_out ? 20'h00000 : pc_load_out});
    end
  end
  initial begin
    #320000;
    err_count++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    // single-step and debug entries left alone
    foreach (fx[i]) run(fx[i], 6'($random(seed)), fa[i], 1'b0);
    break_flag_byte_in = 8'hff;
    vector_table_base_in = 20'h12345;
    run(SRC_BREAK, 6'h09, 20'h12345, 1'b0);
    break_flag_byte_in = 8'h00;
    for (int k = 0; k < 12; k++) begin
      vector_table_base_in = 20'($random(seed));
      global_enable_in = k[1];
      n = k < 4 ? nums[k] : 6'($random(seed));
      run(SRC_SWI, n, vector_table_base_in + {12'h000, n, 2'b00}, 1'b0);
    end
    vector_table_base_in = 20'h40000;
    periph_req_in = 32'h0000_1800;
    periph_mask_in = 32'h0000_0800;
    global_enable_in = 1'b1;
    run(SRC_PERIPH, 6'h0b, 20'h4002c, 1'b0);
    run(SRC_PERIPH, 6'h0c, 20'h00000, 1'b1);
    global_enable_in = 1'b0;
    run(SRC_PERIPH, 6'h0b, 20'h00000, 1'b1);
    for (int k = 0; k < 8; k++) begin
      periph_req_in = $random(seed);
      periph_mask_in = $random(seed);
      sel[1] = 1'b0;
      #1 chk("slot6", 21'(periph_req_in[6] & periph_mask_in[6]), 21'(slot_req_out[6]));
      @(posedge clk_in) #1;
    end
    chk("pending", 21'h0, 21'(exp_q.size()));
    close_out();
  end
endmodule : irq_vector_map_tb
`default_nettype wire
